/* include/tmv_pkg.sv */
// transform mode vector bank: shared constants, field layout and carrier types
// Summary of operation
// - early layout: one 128-bit vector, low word textures, next word light/fog, top unused
// - early low word: texture 0 in bits 0-13, texture 1 same pattern in 14-27
// - perspective bit set multiplies final texture coordinates by 1/w, clear skips it
// - early words carry viewer, lighting, normalize, fog, point size, weight, bypass, viewport_offset_select
// - eight 2-bit light modes in bits 0-15: off, infinite, local, spot
// - early fog select bits 16-17: pass, radial, orthogonal, absolute orthogonal
// - texgen codes 0-5 with per-coordinate limits; emboss only texture 1 s
// - early shadows at 0x400f40/0x400f44; low-word write uploads the vector
// - later single vector: texture 0, texture 1, word A, word B from bit 0
// - two vectors: A,B,C plus unused top; four texture words; C enables clip planes
// - word A holds eight material source fields, back in 0-7, front 19-26
// - word A: program start 8-15, normalize, two-sided, local viewer, lighting
// - word B bit 16 skips viewport transform for screen-space positions
// - word B bit 17 chooses legacy or modern arithmetic
// - word B bit 18 widens context memory access from user entries to all
// - word B fog enable, exponential select, fog select width per generation
// - word B point size compute bit 25, weighting mode bits 26-28
// - word B bit 29 permits context writes and forces serial execution
// - word B bits 30-31 pick fixed, bypass or program operating modes
// - texture word: two textures, enable, matrix, r enable, four 3-bit selects
// - a mode command to a word that the current layout's vectors carry uploads a fresh vector
package tmv_pkg;
	// shadow word offsets on the register port
	localparam logic [23:0] OFS_EARLY_HIGH = 24'h400F40;
	localparam logic [23:0] OFS_EARLY_LOW = 24'h400F44;
	localparam logic [23:0] OFS_CLIP = 24'h400FB0;
	localparam logic [23:0] OFS_LIGHT_FOG = 24'h400FB4;
	localparam logic [23:0] OFS_MATERIAL = 24'h400FB8;
	localparam logic [23:0] OFS_TEX_PAIR1 = 24'h400FBC;
	localparam logic [23:0] OFS_TEX_PAIR0 = 24'h400FC0;
	localparam logic [23:0] OFS_TEX_PAIR2 = 24'h400FC4;
	localparam logic [23:0] OFS_TEX_PAIR3 = 24'h400FC8;
	localparam logic [31:0] WORD_RESET = 32'h0;
	// shadow word indices, also the select of a mode command
	localparam int NUM_WORDS = 9;
	localparam logic [3:0] W_EARLY_HIGH = 4'h0;
	localparam logic [3:0] W_EARLY_LOW = 4'h1;
	localparam logic [3:0] W_B = 4'h2;
	localparam logic [3:0] W_A = 4'h3;
	localparam logic [3:0] W_C = 4'h4;
	localparam logic [3:0] W_T0 = 4'h5;
	localparam int NUM_TEX = 8;
	localparam int NUM_LIGHT = 8;
	localparam int NUM_CLIP = 6;
	// early low word fields
	localparam int E_TEX1_LSB = 14;
	localparam int E_LOCAL_VIEWER = 28;
	localparam int E_LIGHTING = 29;
	localparam int E_NORMALIZE = 30;
	localparam int E_FOG_EN = 31;
	// early high word fields
	localparam int E_FOG_SEL_LSB = 16;
	localparam int E_POINT = 25;
	localparam int E_WEIGHT = 27;
	localparam int E_BYPASS = 28;
	localparam int E_VIEWPORT_OFFSET_SELECT = 29;
	// texture fields: early texture slice, later texture word half
	localparam int TEX_LATER_HALF = 16;
	localparam int ET_S_LSB = 3;
	localparam int ET_T_LSB = 6;
	localparam int ET_R_LSB = 9;
	localparam int ET_Q_LSB = 12;
	localparam int LT_S_LSB = 4;
	localparam int LT_T_LSB = 7;
	localparam int LT_R_LSB = 10;
	localparam int LT_Q_LSB = 13;
	// word A fields
	localparam int A_FRONT_LSB = 19;
	localparam int A_PROG_LSB = 8;
	localparam int A_NORMALIZE = 27;
	localparam int A_TWO_SIDE = 29;
	localparam int A_LOCAL_VIEWER = 30;
	localparam int A_LIGHTING = 31;
	// word B fields
	localparam int B_VP_SKIP = 16;
	localparam int B_ARITH = 17;
	localparam int B_CTX_ACCESS = 18;
	localparam int B_FOG_EN = 19;
	localparam int B_FOG_EXP = 21;
	localparam int B_FOG_SEL_LSB = 22;
	localparam int B_POINT = 25;
	localparam int B_WEIGHT_LSB = 26;
	localparam int B_CTX_WRITE = 29;
	localparam int B_OP_LSB = 30;

	typedef enum logic [1:0] {LAYOUT_EARLY, LAYOUT_ONE_VEC, LAYOUT_TWO_VEC} layout_e;
	typedef enum logic [1:0] {OP_FIXED, OP_BYPASS_V3, OP_PROG_V1, OP_PROG_V2} op_mode_e;
	typedef enum logic [2:0] {GEN_PASS, GEN_EYE, GEN_OBJECT, GEN_SPHERE,
		GEN_NORMAL, GEN_REFLECT, GEN_EMBOSS} gen_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [23:0] addr;
		logic [31:0] wdata;
	} mmio_req_s;

	typedef struct packed {
		logic valid;
		logic [3:0] sel;
		logic [31:0] data;
	} method_s;

	typedef struct packed {
		logic valid;
		logic vsel;
		logic [127:0] vec;
	} mode_cmd_s;

	typedef struct packed {
		logic enable;
		logic matrix;
		logic persp_mul;
		logic r_enable;
		logic emboss;
		logic legal;
		logic [2:0] gen_s;
		logic [2:0] gen_t;
		logic [2:0] gen_r;
		logic [2:0] gen_q;
	} tex_cfg_s;

	typedef struct packed {
		tex_cfg_s [NUM_TEX-1:0] tex;
		logic [NUM_LIGHT-1:0][1:0] light;
		logic [7:0][1:0] material;
		logic [7:0] prog_start;
		logic [NUM_CLIP-1:0] clip_en;
		logic local_viewer, lighting, normalize, two_side;
		logic fog_en, fog_exp;
		logic [2:0] fog_sel;
		logic point_size, vp_skip, arith_modern, ctx_full, ctx_write;
		logic bypass, viewport_offset_select_center;
		logic [2:0] weight;
		op_mode_e op_mode;
	} mode_decode_s;
endpackage

/* rtl/tex_field_decode.sv */
// one texture's mode fields unpacked and checked for legal generation codes
`timescale 1ns/1ps
module tex_field_decode (
	// field source
	input wire logic i_early,
	input wire logic i_emboss_ok,
	input wire logic [15:0] i_bits,
	// decoded texture
	output tmv_pkg::tex_cfg_s o_cfg
);
	logic [2:0] s, t, r, q;

	// early slices pack q in two bits, later words give every select three
	always_comb begin
		if (i_early) begin
			s = i_bits[tmv_pkg::ET_S_LSB +: 3];
			t = i_bits[tmv_pkg::ET_T_LSB +: 3];
			r = i_bits[tmv_pkg::ET_R_LSB +: 3];
			q = {1'b0, i_bits[tmv_pkg::ET_Q_LSB +: 2]};
		end else begin
			s = i_bits[tmv_pkg::LT_S_LSB +: 3];
			t = i_bits[tmv_pkg::LT_T_LSB +: 3];
			r = i_bits[tmv_pkg::LT_R_LSB +: 3];
			q = i_bits[tmv_pkg::LT_Q_LSB +: 3];
		end
	end

	// later words have no perspective bit, so the 1/w multiply is off there
	always_comb begin
		o_cfg.enable = i_bits[0];
		o_cfg.matrix = i_bits[1];
		o_cfg.persp_mul = i_early & i_bits[0] & i_bits[2];
		o_cfg.r_enable = i_early | i_bits[2];
		o_cfg.gen_s = s;
		o_cfg.gen_t = t;
		o_cfg.gen_r = r;
		o_cfg.gen_q = q;
		o_cfg.emboss = i_bits[0] & (s == tmv_pkg::GEN_EMBOSS) & i_emboss_ok;
		// sphere only s,t; normal/reflect not q; emboss only on texture 1 s
		o_cfg.legal = !i_bits[0] || ((s <= tmv_pkg::GEN_REFLECT || o_cfg.emboss)
			&& t <= tmv_pkg::GEN_REFLECT && r <= tmv_pkg::GEN_REFLECT
			&& r != tmv_pkg::GEN_SPHERE && q <= tmv_pkg::GEN_OBJECT);
	end
endmodule // tex_field_decode

/* rtl/light_order_check.sv */
// flags a light programmed on after a lower-numbered light that is off
`timescale 1ns/1ps
module light_order_check (
	// packed light modes, light 0 in the low pair
	input wire logic [15:0] i_modes,
	// ordering fault
	output logic o_err
);
	logic [tmv_pkg::NUM_LIGHT:0] seen_off;
	logic [tmv_pkg::NUM_LIGHT-1:0] bad;

	assign seen_off[0] = 1'b0;
	// carry "an earlier light is off" up the chain
	for (genvar g = 0; g < tmv_pkg::NUM_LIGHT; g++) begin : g_light
		assign bad[g] = seen_off[g] && (i_modes[2*g +: 2] != 2'h0);
		assign seen_off[g+1] = seen_off[g] || (i_modes[2*g +: 2] == 2'h0);
	end
	assign o_err = |bad;
endmodule // light_order_check

/* rtl/transform_mode_vector_bank.sv */
// shadow mode words, upload of mode vectors and decode of the current shadow words
`timescale 1ns/1ps
module transform_mode_vector_bank (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// layout strap, not timed to the core clock
	input wire logic [1:0] I_LAYOUT,
	// shadow word access
	input wire tmv_pkg::mmio_req_s I_MMIO,
	output logic [31:0] O_MMIO_RDATA,
	output logic O_MMIO_RVALID,
	// mode-changing commands from the command decoder
	input wire tmv_pkg::method_s I_METHOD,
	// mode upload to the transform engine
	output tmv_pkg::mode_cmd_s O_MODE_CMD,
	// mode decoded from the current shadow words, and programming faults
	output tmv_pkg::mode_decode_s O_DECODE,
	output logic O_LIGHT_ORDER_ERR,
	output logic O_TEX_GEN_ERR
);
	typedef struct packed {
		logic [1:0] lay_meta;
		logic [1:0] lay_sync;
		logic [tmv_pkg::NUM_WORDS-1:0][31:0] word;
		logic [1:0] pend;
		tmv_pkg::mode_cmd_s cmd;
		logic [31:0] rdata;
		logic rvalid;
		tmv_pkg::mode_decode_s dec;
		logic light_err;
		logic tex_err;
	} state_s;

	state_s st_r;
	state_s st_nxt;
	tmv_pkg::layout_e lay;
	logic map_hit;
	logic [3:0] map_idx;
	logic [1:0] touch;
	logic mmio_wr;
	logic meth_wr;
	logic [127:0] vec0;
	logic [127:0] vec1;
	tmv_pkg::tex_cfg_s [tmv_pkg::NUM_TEX-1:0] tex_cfg;
	logic light_err_early;
	logic light_err_later;

	// which vector a written word belongs to, per layout
	function automatic logic [1:0] touch_mask(input logic [3:0] idx,
		input tmv_pkg::layout_e l);
		logic [1:0] m;
		m = 2'b00;
		unique case (l)
		tmv_pkg::LAYOUT_EARLY: m[0] = (idx == tmv_pkg::W_EARLY_LOW);
		tmv_pkg::LAYOUT_ONE_VEC: m[0] = (idx >= tmv_pkg::W_B) && (idx != tmv_pkg::W_C)
			&& (idx <= tmv_pkg::W_T0 + 4'h1);
		tmv_pkg::LAYOUT_TWO_VEC: begin
			m[0] = (idx >= tmv_pkg::W_B) && (idx <= tmv_pkg::W_C);
			m[1] = (idx >= tmv_pkg::W_T0);
		end
		endcase
		return m;
	endfunction

	// strap value 3 has no layout; it falls back to the early one
	always_comb begin
		unique case (st_r.lay_sync)
		2'h1: lay = tmv_pkg::LAYOUT_ONE_VEC;
		2'h2: lay = tmv_pkg::LAYOUT_TWO_VEC;
		default: lay = tmv_pkg::LAYOUT_EARLY;
		endcase
	end

	// address decode of the shadow words; anything else is unmapped
	always_comb begin
		map_hit = 1'b1;
		map_idx = tmv_pkg::W_EARLY_HIGH;
		case (I_MMIO.addr)
		tmv_pkg::OFS_EARLY_HIGH: map_idx = tmv_pkg::W_EARLY_HIGH;
		tmv_pkg::OFS_EARLY_LOW: map_idx = tmv_pkg::W_EARLY_LOW;
		tmv_pkg::OFS_LIGHT_FOG: map_idx = tmv_pkg::W_B;
		tmv_pkg::OFS_MATERIAL: map_idx = tmv_pkg::W_A;
		tmv_pkg::OFS_CLIP: map_idx = tmv_pkg::W_C;
		tmv_pkg::OFS_TEX_PAIR0: map_idx = tmv_pkg::W_T0;
		tmv_pkg::OFS_TEX_PAIR1: map_idx = tmv_pkg::W_T0 + 4'h1;
		tmv_pkg::OFS_TEX_PAIR2: map_idx = tmv_pkg::W_T0 + 4'h2;
		tmv_pkg::OFS_TEX_PAIR3: map_idx = tmv_pkg::W_T0 + 4'h3;
		default: map_hit = 1'b0;
		endcase
	end

	assign mmio_wr = I_MMIO.wr && map_hit;
	assign meth_wr = I_METHOD.valid && (I_METHOD.sel < 4'(tmv_pkg::NUM_WORDS));

	// vectors that need an upload because of this cycle's writes
	always_comb begin
		touch = 2'b00;
		if (mmio_wr) begin
			touch = touch | touch_mask(map_idx, lay);
		end
		if (meth_wr) begin
			touch = touch | touch_mask(I_METHOD.sel, lay);
			if (lay == tmv_pkg::LAYOUT_EARLY && I_METHOD.sel == tmv_pkg::W_EARLY_HIGH) begin
				touch[0] = 1'b1;
			end
		end
	end

	// vectors are built from the shadow at send time, so a burst sends the latest
	always_comb begin
		vec1 = {st_r.word[tmv_pkg::W_T0 + 4'h3], st_r.word[tmv_pkg::W_T0 + 4'h2],
			st_r.word[tmv_pkg::W_T0 + 4'h1], st_r.word[tmv_pkg::W_T0]};
		unique case (lay)
		tmv_pkg::LAYOUT_EARLY: vec0 = {64'h0, st_r.word[tmv_pkg::W_EARLY_HIGH],
			st_r.word[tmv_pkg::W_EARLY_LOW]};
		tmv_pkg::LAYOUT_ONE_VEC: vec0 = {st_r.word[tmv_pkg::W_B], st_r.word[tmv_pkg::W_A],
			st_r.word[tmv_pkg::W_T0 + 4'h1], st_r.word[tmv_pkg::W_T0]};
		tmv_pkg::LAYOUT_TWO_VEC: vec0 = {32'h0, st_r.word[tmv_pkg::W_C],
			st_r.word[tmv_pkg::W_B], st_r.word[tmv_pkg::W_A]};
		endcase
	end

	// texture decoders: early layout uses two slices of the low word
	for (genvar g = 0; g < tmv_pkg::NUM_TEX; g++) begin : g_tex
		logic [15:0] bits;
		logic early_tex;
		localparam logic [3:0] TW = tmv_pkg::W_T0 + 4'(g / 2);
		assign early_tex = (lay == tmv_pkg::LAYOUT_EARLY);
		always_comb begin
			bits = 16'h0;
			unique case (lay)
			tmv_pkg::LAYOUT_EARLY: if (g < 2) begin
				bits = {2'b00, st_r.word[tmv_pkg::W_EARLY_LOW][(g % 2) * tmv_pkg::E_TEX1_LSB +: 14]};
			end
			tmv_pkg::LAYOUT_ONE_VEC: if (g < 4) begin
				bits = st_r.word[TW][(g % 2) * tmv_pkg::TEX_LATER_HALF +: 16];
			end
			tmv_pkg::LAYOUT_TWO_VEC: bits = st_r.word[TW][(g % 2) * tmv_pkg::TEX_LATER_HALF +: 16];
			endcase
		end
		tex_field_decode u_tex (
			.i_early(early_tex),
			.i_emboss_ok(g == 1),
			.i_bits(bits),
			.o_cfg(tex_cfg[g])
		);
	end

	// light ordering checked on whichever word carries the light modes
	light_order_check u_light_early (
		.i_modes(st_r.word[tmv_pkg::W_EARLY_HIGH][15:0]),
		.o_err(light_err_early)
	);
	light_order_check u_light_later (
		.i_modes(st_r.word[tmv_pkg::W_B][15:0]),
		.o_err(light_err_later)
	);

	// next state: shadow writes, upload queue, read return and decode
	always_comb begin
		logic [31:0] wa;
		logic [31:0] wb;
		logic [31:0] el;
		logic [31:0] eh;
		wa = st_r.word[tmv_pkg::W_A];
		wb = st_r.word[tmv_pkg::W_B];
		el = st_r.word[tmv_pkg::W_EARLY_LOW];
		eh = st_r.word[tmv_pkg::W_EARLY_HIGH];
		st_nxt = st_r;
		// strap synchroniser, second stage is the only reader of the first
		st_nxt.lay_meta = I_LAYOUT;
		st_nxt.lay_sync = st_r.lay_meta;
		// a command on the same word as a register write lands last and wins
		if (mmio_wr) begin
			st_nxt.word[map_idx] = I_MMIO.wdata;
		end
		if (meth_wr) begin
			st_nxt.word[I_METHOD.sel] = I_METHOD.data;
		end
		// one upload per cycle, vector 0 first; a new write never loses its bit
		st_nxt.cmd.valid = 1'b0;
		st_nxt.cmd.vsel = 1'b0;
		st_nxt.cmd.vec = st_r.cmd.vec;
		if (st_r.pend[0]) begin
			st_nxt.cmd.valid = 1'b1;
			st_nxt.cmd.vec = vec0;
			st_nxt.pend[0] = 1'b0;
		end else if (st_r.pend[1]) begin
			st_nxt.cmd.valid = 1'b1;
			st_nxt.cmd.vsel = 1'b1;
			st_nxt.cmd.vec = vec1;
			st_nxt.pend[1] = 1'b0;
		end
		st_nxt.pend = st_nxt.pend | touch;
		// reads return one cycle later; unmapped addresses read zero
		st_nxt.rvalid = I_MMIO.rd;
		st_nxt.rdata = (I_MMIO.rd && map_hit) ? st_r.word[map_idx] : 32'h0;
		// decode of the current shadow, aligned with the upload it feeds
		st_nxt.dec = '0;
		st_nxt.dec.tex = tex_cfg;
		st_nxt.tex_err = 1'b0;
		for (int i = 0; i < tmv_pkg::NUM_TEX; i++) begin
			st_nxt.tex_err = st_nxt.tex_err | !tex_cfg[i].legal;
		end
		if (lay == tmv_pkg::LAYOUT_EARLY) begin
			st_nxt.dec.light = eh[15:0];
			st_nxt.dec.local_viewer = el[tmv_pkg::E_LOCAL_VIEWER];
			st_nxt.dec.lighting = el[tmv_pkg::E_LIGHTING];
			st_nxt.dec.normalize = el[tmv_pkg::E_NORMALIZE];
			st_nxt.dec.fog_en = el[tmv_pkg::E_FOG_EN];
			st_nxt.dec.fog_sel = {1'b0, eh[tmv_pkg::E_FOG_SEL_LSB +: 2]};
			st_nxt.dec.point_size = eh[tmv_pkg::E_POINT];
			st_nxt.dec.weight = {2'b00, eh[tmv_pkg::E_WEIGHT]};
			st_nxt.dec.bypass = eh[tmv_pkg::E_BYPASS];
			st_nxt.dec.viewport_offset_select_center = eh[tmv_pkg::E_VIEWPORT_OFFSET_SELECT];
			st_nxt.dec.op_mode = eh[tmv_pkg::E_BYPASS] ? tmv_pkg::OP_BYPASS_V3
				: tmv_pkg::OP_FIXED;
			st_nxt.light_err = light_err_early;
		end else begin
			st_nxt.dec.light = wb[15:0];
			st_nxt.dec.material = {wa[tmv_pkg::A_FRONT_LSB +: 8], wa[7:0]};
			st_nxt.dec.prog_start = wa[tmv_pkg::A_PROG_LSB +: 8];
			st_nxt.dec.normalize = wa[tmv_pkg::A_NORMALIZE];
			st_nxt.dec.two_side = wa[tmv_pkg::A_TWO_SIDE];
			st_nxt.dec.local_viewer = wa[tmv_pkg::A_LOCAL_VIEWER];
			st_nxt.dec.lighting = wa[tmv_pkg::A_LIGHTING];
			st_nxt.dec.vp_skip = wb[tmv_pkg::B_VP_SKIP];
			st_nxt.dec.arith_modern = wb[tmv_pkg::B_ARITH];
			st_nxt.dec.ctx_full = wb[tmv_pkg::B_CTX_ACCESS];
			st_nxt.dec.fog_en = wb[tmv_pkg::B_FOG_EN];
			st_nxt.dec.fog_exp = wb[tmv_pkg::B_FOG_EXP];
			// the earlier part has a 3-bit fog select, the later one only two
			st_nxt.dec.fog_sel = (lay == tmv_pkg::LAYOUT_ONE_VEC)
				? wb[tmv_pkg::B_FOG_SEL_LSB +: 3]
				: {1'b0, wb[tmv_pkg::B_FOG_SEL_LSB +: 2]};
			st_nxt.dec.point_size = wb[tmv_pkg::B_POINT];
			st_nxt.dec.weight = wb[tmv_pkg::B_WEIGHT_LSB +: 3];
			st_nxt.dec.ctx_write = wb[tmv_pkg::B_CTX_WRITE];
			st_nxt.dec.op_mode = tmv_pkg::op_mode_e'(wb[tmv_pkg::B_OP_LSB +: 2]);
			st_nxt.dec.bypass = (lay == tmv_pkg::LAYOUT_ONE_VEC)
				&& (wb[tmv_pkg::B_OP_LSB +: 2] == 2'h1);
			if (lay == tmv_pkg::LAYOUT_TWO_VEC) begin
				st_nxt.dec.clip_en = st_r.word[tmv_pkg::W_C][5:0];
			end
			st_nxt.light_err = light_err_later;
		end
	end

	// all state, shadow words included, clears to zero: fixed function, all off
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign O_MMIO_RDATA = st_r.rdata;
	assign O_MMIO_RVALID = st_r.rvalid;
	assign O_MODE_CMD = st_r.cmd;
	assign O_DECODE = st_r.dec;
	assign O_LIGHT_ORDER_ERR = st_r.light_err;
	assign O_TEX_GEN_ERR = st_r.tex_err;

	// a low-word write in the early layout is uploaded two edges later
	AST_EARLY_UPLOAD: assert property (@(posedge I_CLK) disable iff (I_RST)
		lay == tmv_pkg::LAYOUT_EARLY && mmio_wr && map_idx == tmv_pkg::W_EARLY_LOW
		|=> ##1 O_MODE_CMD.valid && !O_MODE_CMD.vsel)
		else $error("early low-word write not uploaded");

	// a register write to the early high word alone does not upload
	AST_EARLY_HIGH_QUIET: assert property (@(posedge I_CLK) disable iff (I_RST)
		lay == tmv_pkg::LAYOUT_EARLY && $stable(lay) && !st_r.pend[0] && !meth_wr
		&& mmio_wr && map_idx == tmv_pkg::W_EARLY_HIGH |=> ##1 !O_MODE_CMD.valid)
		else $error("early high-word write uploaded");

	// early vector keeps its upper half zero
	AST_EARLY_TOP_ZERO: assert property (@(posedge I_CLK) disable iff (I_RST)
		st_r.pend[0] && lay == tmv_pkg::LAYOUT_EARLY |=> O_MODE_CMD.vec[127:64] == 64'h0)
		else $error("early vector upper half not zero");

	// vector 0 of the two-vector layout leaves its top word empty
	AST_TWO_VEC_TOP: assert property (@(posedge I_CLK) disable iff (I_RST)
		O_MODE_CMD.valid && !O_MODE_CMD.vsel && $past(lay) == tmv_pkg::LAYOUT_TWO_VEC
		|-> O_MODE_CMD.vec[127:96] == 32'h0)
		else $error("two-vector top word not zero");

	// a two-vector-layout register write to word B or above is uploaded within three edges
	AST_LATER_UPLOAD: assert property (@(posedge I_CLK) disable iff (I_RST)
		lay == tmv_pkg::LAYOUT_TWO_VEC && $stable(lay) && mmio_wr
		&& map_idx >= tmv_pkg::W_B |-> ##[2:3] O_MODE_CMD.valid)
		else $error("later-layout write not uploaded");

	// early layout: perspective multiply follows texture 0's enable and perspective bits
	AST_PERSP: assert property (@(posedge I_CLK) disable iff (I_RST)
		lay == tmv_pkg::LAYOUT_EARLY |=> O_DECODE.tex[0].persp_mul
		== ($past(st_r.word[tmv_pkg::W_EARLY_LOW][0]) && $past(st_r.word[tmv_pkg::W_EARLY_LOW][2])))
		else $error("perspective multiply mismatch");

	// operating mode tracks word B bits 30-31
	AST_OP_MODE: assert property (@(posedge I_CLK) disable iff (I_RST)
		lay != tmv_pkg::LAYOUT_EARLY |=> O_DECODE.op_mode == $past(st_r.word[tmv_pkg::W_B][31:30]))
		else $error("operating mode mismatch");

	// viewport skip tracks word B bit 16
	AST_VP_SKIP: assert property (@(posedge I_CLK) disable iff (I_RST)
		lay != tmv_pkg::LAYOUT_EARLY |=> O_DECODE.vp_skip == $past(st_r.word[tmv_pkg::W_B][16]))
		else $error("viewport skip mismatch");

	// shadow words are zero on the first edge after reset
	AST_RESET_ZERO: assert property (@(posedge I_CLK) disable iff (I_RST)
		$fell(I_RST) |-> st_r.word == '0 && !O_MODE_CMD.valid)
		else $error("shadow not zero after reset");

	// early light modes come straight from the high word
	AST_EARLY_LIGHTS: assert property (@(posedge I_CLK) disable iff (I_RST)
		lay == tmv_pkg::LAYOUT_EARLY
		|=> O_DECODE.light == $past(st_r.word[tmv_pkg::W_EARLY_HIGH][15:0]))
		else $error("early light modes mismatch");

	// material sources: front pairs above back pairs, both straight from word A
	AST_MATERIAL: assert property (@(posedge I_CLK) disable iff (I_RST)
		lay != tmv_pkg::LAYOUT_EARLY |=> O_DECODE.material
		== {$past(st_r.word[tmv_pkg::W_A][26:19]), $past(st_r.word[tmv_pkg::W_A][7:0])})
		else $error("material source mismatch");

	// clip plane enables follow word C in the two-vector layout
	AST_CLIP: assert property (@(posedge I_CLK) disable iff (I_RST)
		lay == tmv_pkg::LAYOUT_TWO_VEC
		|=> O_DECODE.clip_en == $past(st_r.word[tmv_pkg::W_C][5:0]))
		else $error("clip enable mismatch");

	// the later part has a 2-bit fog select, so the top bit must read zero
	AST_FOG_SEL_TWO: assert property (@(posedge I_CLK) disable iff (I_RST)
		lay == tmv_pkg::LAYOUT_TWO_VEC
		|=> O_DECODE.fog_sel == {1'b0, $past(st_r.word[tmv_pkg::W_B][23:22])})
		else $error("two-vector fog select mismatch");

	// a two-vector-layout mode command to word B or above is uploaded within three edges
	AST_METHOD_UPLOAD: assert property (@(posedge I_CLK) disable iff (I_RST)
		lay == tmv_pkg::LAYOUT_TWO_VEC && $stable(lay) && meth_wr
		&& I_METHOD.sel >= tmv_pkg::W_B |-> ##[2:3] O_MODE_CMD.valid)
		else $error("mode command not uploaded");

	// q has no sphere map in the early slice, so code 3 there is a fault
	AST_EARLY_Q_ILLEGAL: assert property (@(posedge I_CLK) disable iff (I_RST)
		lay == tmv_pkg::LAYOUT_EARLY && st_r.word[tmv_pkg::W_EARLY_LOW][0]
		&& st_r.word[tmv_pkg::W_EARLY_LOW][13:12] == 2'h3 |=> O_TEX_GEN_ERR)
		else $error("illegal q generation not flagged");

	// unmapped reads still answer, with zero, so a poller never hangs
	AST_UNMAPPED_READ: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_MMIO.rd && !map_hit |=> O_MMIO_RVALID && O_MMIO_RDATA == 32'h0)
		else $error("unmapped read not answered with zero");
endmodule // transform_mode_vector_bank

/* dv/mode_sink.sv */
// transform engine stand-in: accepts every mode upload at once
`timescale 1ns/1ps
module mode_sink (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// upload from the bank
	input wire tmv_pkg::mode_cmd_s i_cmd,
	// last upload seen, flagged for one cycle
	output logic o_got,
	output logic [128:0] o_rx
);
	// the real engine never stalls a mode load, so neither does this one
	always_ff @(posedge i_clk) begin
		o_got <= i_cmd.valid && !i_rst;
		if (i_cmd.valid) begin
			o_rx <= {i_cmd.vsel, i_cmd.vec};
		end
	end
endmodule // mode_sink

/* dv/transform_mode_vector_bank_tb.sv */
// self-checking bench for the transform mode vector bank
`timescale 1ns/1ps
module transform_mode_vector_bank_tb;
	logic I_CLK = 0, I_RST = 1, O_MMIO_RVALID, O_LIGHT_ORDER_ERR, O_TEX_GEN_ERR, got;
	logic [1:0] I_LAYOUT = 2'h0;
	tmv_pkg::mmio_req_s I_MMIO = '0;
	tmv_pkg::method_s I_METHOD = '0;
	tmv_pkg::mode_cmd_s O_MODE_CMD;
	tmv_pkg::mode_decode_s O_DECODE;
	logic [31:0] O_MMIO_RDATA, d;
	logic [128:0] rx;
	logic [128:0] uq[$];
	logic [31:0] rq[$];
	logic [31:0] sh[9];
	logic [23:0] ofs[9];
	int mismatches = 0, n_tests = 0, lay = 0;

	always #2.5 I_CLK = ~I_CLK;

	transform_mode_vector_bank u_transform_mode_vector_bank (.I_CLK(I_CLK), .I_RST(I_RST),
		.I_LAYOUT(I_LAYOUT), .I_MMIO(I_MMIO), .O_MMIO_RDATA(O_MMIO_RDATA),
		.O_MMIO_RVALID(O_MMIO_RVALID), .I_METHOD(I_METHOD), .O_MODE_CMD(O_MODE_CMD),
		.O_DECODE(O_DECODE), .O_LIGHT_ORDER_ERR(O_LIGHT_ORDER_ERR),
		.O_TEX_GEN_ERR(O_TEX_GEN_ERR));
	mode_sink u_mode_sink (.i_clk(I_CLK), .i_rst(I_RST), .i_cmd(O_MODE_CMD), .o_got(got),
		.o_rx(rx));

	task automatic check(string nm, logic [128:0] seen, logic [128:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		if (mismatches == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// expected vector built from the bench's own copy of the shadow words
	function automatic logic [127:0] vec_of(bit v);
		if (lay == 0) return {64'h0, sh[0], sh[1]};
		if (lay == 1) return {sh[2], sh[3], sh[6], sh[5]};
		return v ? {sh[8], sh[7], sh[6], sh[5]} : {32'h0, sh[4], sh[2], sh[3]};
	endfunction

	// one word write by register (m=0) or mode command (m=1); spaced so uploads never merge
	task automatic put(int i, logic [31:0] v, bit m);
		bit up;
		bit s;
		up = (lay == 0) ? (m ? i < 2 : i == 1) : (lay == 1) ? (i inside {2, 3, 5, 6}) : i >= 2;
		s = (lay == 2) && i >= 5;
		@(negedge I_CLK);
		if (i < 9) sh[i] = v;
		if (up && i < 9) uq.push_back({s, vec_of(s)});
		if (m) I_METHOD = '{1'b1, i[3:0], v};
		else I_MMIO = '{1'b1, 1'b0, ofs[i], v};
		@(negedge I_CLK);
		I_METHOD = '0;
		I_MMIO = '0;
		repeat (4) @(negedge I_CLK);
	endtask

	task automatic rd(logic [23:0] a, logic [31:0] e);
		@(negedge I_CLK);
		rq.push_back(e);
		I_MMIO = '{1'b0, 1'b1, a, 32'h0};
		@(negedge I_CLK);
		I_MMIO = '0;
	endtask

	// watchers: every result takes the oldest note; a result with no note is a fault
	always @(posedge I_CLK) begin
		// an unknown strobe is looked at too, so it cannot slip past unseen
		if (!I_RST && got !== 1'b0)
			check("upload", rx, (uq.size() > 0) ? uq.pop_front() : ~rx);
		if (!I_RST && O_MMIO_RVALID !== 1'b0)
			check("rdata", O_MMIO_RDATA, (rq.size() > 0) ? rq.pop_front() : ~O_MMIO_RDATA);
	end

	initial begin
		#200000;
		mismatches++;
		test_done();
	end

	initial begin
		ofs = '{tmv_pkg::OFS_EARLY_HIGH, tmv_pkg::OFS_EARLY_LOW, tmv_pkg::OFS_LIGHT_FOG,
			tmv_pkg::OFS_MATERIAL, tmv_pkg::OFS_CLIP, tmv_pkg::OFS_TEX_PAIR0,
			tmv_pkg::OFS_TEX_PAIR1, tmv_pkg::OFS_TEX_PAIR2, tmv_pkg::OFS_TEX_PAIR3};
		foreach (sh[i]) sh[i] = 32'h0;
		d = $urandom(24);
		repeat (10) @(negedge I_CLK);
		I_RST = 0;
		for (int i = 0; i < 9; i++) rd(ofs[i], 32'h0);
		rd(24'h400F00, 32'h0);
		// early layout: high word register write alone stores, low word uploads
		d = $urandom();
		put(0, {d[31:16], 16'h0004}, 0);
		d = $urandom();
		put(1, d | 32'h00008002, 0);
		check("lights", O_DECODE.light, 16'h0004);
		check("order", O_LIGHT_ORDER_ERR, 1'b1);
		check("viewport_offset_select", O_DECODE.viewport_offset_select_center, sh[0][29]);
		check("fog sel", O_DECODE.fog_sel, {1'b0, sh[0][17:16]});
		check("light fog", {O_DECODE.lighting, O_DECODE.fog_en}, {sh[1][29], sh[1][31]});
		put(0, {sh[0][31:16], 16'h0055}, 1);
		check("order", O_LIGHT_ORDER_ERR, 1'b0);
		put(1, 32'h00003007, 1);
		check("texgen", {O_TEX_GEN_ERR, O_DECODE.tex[0].persp_mul}, 2'h3);
		put(1, 32'h000CC003, 0);
		check("texgen", {O_TEX_GEN_ERR, O_DECODE.tex[0].persp_mul,
			O_DECODE.tex[1].emboss}, 3'h1);
		put(9, 32'hFFFFFFFF, 1);
		rd(ofs[0], sh[0]);
		rd(ofs[1], sh[1]);
		// later one-vector layout: every operating mode code
		lay = 1;
		I_LAYOUT = 2'h1;
		repeat (4) @(negedge I_CLK);
		for (int c = 0; c < 4; c++) begin
			d = $urandom();
			put(2, {c[1:0], d[29:0]}, c[0]);
			check("op mode", O_DECODE.op_mode, c[1:0]);
			check("fog sel b", O_DECODE.fog_sel, sh[2][24:22]);
		end
		put(3, $urandom(), 0);
		check("prog start", O_DECODE.prog_start, sh[3][15:8]);
		check("word a", {O_DECODE.material, O_DECODE.normalize, O_DECODE.two_side,
			O_DECODE.local_viewer, O_DECODE.lighting},
			{sh[3][26:19], sh[3][7:0], sh[3][27], sh[3][29], sh[3][30], sh[3][31]});
		put(5, $urandom() | 32'h00020002, 1);
		check("tex pair", {O_DECODE.tex[0].r_enable, O_DECODE.tex[0].gen_q,
			O_DECODE.tex[1].gen_s}, {sh[5][2], sh[5][15:13], sh[5][22:20]});
		put(4, $urandom(), 0);
		// two-vector layout: vector 0 then vector 1
		lay = 2;
		I_LAYOUT = 2'h2;
		repeat (4) @(negedge I_CLK);
		d = $urandom();
		put(2, d, 1);
		check("word b", {O_DECODE.vp_skip, O_DECODE.arith_modern,
			O_DECODE.ctx_full, O_DECODE.ctx_write, O_DECODE.point_size, O_DECODE.fog_exp,
			O_DECODE.weight, O_DECODE.light, O_DECODE.fog_en, O_DECODE.fog_sel},
			{d[16], d[17], d[18], d[29], d[25], d[21], d[28:26], d[15:0], d[19], 1'b0, d[23:22]});
		put(4, $urandom(), 1);
		check("clip", O_DECODE.clip_en, sh[4][5:0]);
		put(8, $urandom() | 32'h00020002, 0);
		// strap code 3 has no layout of its own and must behave as the early one
		lay = 0;
		I_LAYOUT = 2'h3;
		repeat (4) @(negedge I_CLK);
		put(1, sh[1] ^ 32'h00000001, 0);
		check("early op", O_DECODE.op_mode, {1'b0, sh[0][28]});
		for (int i = 0; i < 9; i++) rd(ofs[i], sh[i]);
		repeat (4) @(negedge I_CLK);
		check("pending", uq.size() + rq.size(), 0);
		test_done();
	end
endmodule // transform_mode_vector_bank_tb
